// ### logic/pbt_bridge.sv
/*
  peripheral bus access timing bridge: takes one register access from the
  main bus, decodes the target bus, adds synchronisation cycles and
  answers with a ready pulse after the documented cost.
  assumes the master holds a request until ready and keeps only one open.
*/
`timescale 1ns/1ps
module pbt_bridge #(
  parameter logic [3:0] DIV_A   = pbt_pkg::DIV_A_DEF,
  parameter logic [3:0] DIV_B   = pbt_pkg::DIV_B_DEF,
  parameter logic [3:0] DIV_EXT = pbt_pkg::DIV_EXT_DEF
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        acc_req,
  input  wire logic [31:0] acc_addr,
  input  wire logic [1:0]  acc_size,
  input  wire logic [2:0]  acc_bus,
  input  wire logic        contend,
  output logic             acc_ready,
  output logic             acc_size_err,
  output logic [7:0]       acc_cycles,
  output logic             acc_busy
);
  typedef enum logic [1:0] {
    PBT_IDLE = 2'b00,
    PBT_MAIN = 2'b01,
    PBT_PERI = 2'b11,
    PBT_DONE = 2'b10
  } pbt_state_t;

  pbt_state_t state_q;
  logic [3:0] div_a_q;
  logic [3:0] div_b_q;
  logic [3:0] div_ext_q;
  logic       en_a_q;
  logic       en_b_q;
  logic       en_ext_q;
  logic [3:0] main_q;
  logic [7:0] cyc_q;
  logic       ready_q;
  logic       err_q;
  logic [7:0] cyc_out_q;
  logic       start_q;
  logic [2:0] bus_q;
  logic       sync_q;
  pbt_req_if  req ();

  // true when address falls in an inclusive window
  function automatic logic in_win(input logic [31:0] a,
                                  input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction

  // one divider step; pulse when the count wraps
  function automatic logic [3:0] div_next(input logic [3:0] c,
                                          input logic [3:0] n);
    div_next = (c >= n - 4'h1) ? 4'h0 : c + 4'h1;
  endfunction

  // only the four group registers; the gaps between them are plain space
  function automatic logic is_grp(input logic [31:0] a);
    is_grp = (a == pbt_pkg::ADDR_GRP_REQ0) || (a == pbt_pkg::ADDR_GRP_REQ1)
          || (a == pbt_pkg::ADDR_GRP_EN0) || (a == pbt_pkg::ADDR_GRP_EN1);
  endfunction

  // the interrupt unit registers accept only their documented size
  function automatic logic size_bad(input logic [31:0] a,
                                    input logic [1:0] s);
    size_bad = 1'b0;
    if (in_win(a, pbt_pkg::ADDR_INT_B_SEL_LO, pbt_pkg::ADDR_INT_B_SEL_HI))
      size_bad = (s != pbt_pkg::SZ_BYTE);
    else if (is_grp(a))
      size_bad = (s != pbt_pkg::SZ_WORD);
    else if (in_win(a, pbt_pkg::ADDR_INT_A_LO, pbt_pkg::ADDR_INT_A_HI))
      size_bad = (s != pbt_pkg::SZ_BYTE);
  endfunction

  // bus of the interrupt unit windows overrides the requested bus
  function automatic logic [2:0] bus_of(input logic [31:0] a,
                                        input logic [2:0] b);
    bus_of = b;
    if (in_win(a, pbt_pkg::ADDR_INT_B_SEL_LO, pbt_pkg::ADDR_INT_B_SEL_HI))
      bus_of = pbt_pkg::BUS_P2;
    else if (is_grp(a)
          || in_win(a, pbt_pkg::ADDR_INT_A_LO, pbt_pkg::ADDR_INT_A_HI))
      bus_of = pbt_pkg::BUS_P1;
  endfunction

  // divided clock enables; a ratio of one pulses every core cycle
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_a_q   <= 4'h0;
      div_b_q   <= 4'h0;
      div_ext_q <= 4'h0;
      en_a_q    <= 1'b0;
      en_b_q    <= 1'b0;
      en_ext_q  <= 1'b0;
    end
    else
    begin
      div_a_q   <= div_next(div_a_q, DIV_A);
      div_b_q   <= div_next(div_b_q, DIV_B);
      div_ext_q <= div_next(div_ext_q, DIV_EXT);
      en_a_q    <= (div_next(div_a_q, DIV_A) == 4'h0);
      en_b_q    <= (div_next(div_b_q, DIV_B) == 4'h0);
      en_ext_q  <= (div_next(div_ext_q, DIV_EXT) == 4'h0);
    end
  end

  // access sequencer: main bus, then sync and peripheral stage
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= PBT_IDLE;
      main_q  <= 4'h0;
      start_q <= 1'b0;
      bus_q   <= 3'h0;
      sync_q  <= 1'b0;
      err_q   <= 1'b0;
    end
    else
    begin
      start_q <= 1'b0;
      case (state_q)
        PBT_IDLE:
        begin
          // contention stalls the start, so the fixed cost is not claimed
          if (acc_req && !contend)
          begin
            state_q <= PBT_MAIN;
            main_q  <= pbt_pkg::MAIN_BUS_CYC - 4'h1;
            bus_q   <= bus_of(acc_addr, acc_bus);
            err_q   <= size_bad(acc_addr, acc_size);
            sync_q  <= (bus_of(acc_addr, acc_bus) >= pbt_pkg::BUS_P2
                        && bus_of(acc_addr, acc_bus) <= pbt_pkg::BUS_P6)
                    || (bus_of(acc_addr, acc_bus) == pbt_pkg::BUS_EXT
                        && !in_win(acc_addr, pbt_pkg::ADDR_BUS_ERR_LO,
                                   pbt_pkg::ADDR_BUS_ERR_HI));
          end
        end
        PBT_MAIN:
        begin
          // the sync stage is started only once the main bus cycles have run out
          if (main_q == 4'h0)
          begin
            state_q <= PBT_PERI;
            start_q <= 1'b1;
          end
          else
            main_q <= main_q - 4'h1;
        end
        PBT_PERI:
        begin
          if (req.done)
            state_q <= PBT_DONE;
        end
        PBT_DONE:
          state_q <= PBT_IDLE;
        default:
          state_q <= PBT_IDLE;
      endcase
    end
  end

  // running cost counter for the access in flight
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      cyc_q <= 8'h00;
    else if (state_q == PBT_IDLE)
      cyc_q <= 8'h00;
    else if (state_q != PBT_DONE)
      cyc_q <= cyc_q + 8'h01;
  end

  // answer outputs, all registered
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ready_q   <= 1'b0;
      cyc_out_q <= 8'h00;
    end
    else
    begin
      ready_q <= (state_q == PBT_PERI) && req.done;
      if ((state_q == PBT_PERI) && req.done)
        cyc_out_q <= cyc_q + 8'h01;
    end
  end

  assign req.start     = start_q;
  assign req.bus       = bus_q;
  assign req.need_sync = sync_q;

  pbt_sync u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .en_a    (en_a_q),
    .en_b    (en_b_q),
    .en_ext  (en_ext_q),
    .req     (req.sync)
  );

  assign acc_ready    = ready_q;
  assign acc_size_err = err_q;
  assign acc_cycles   = cyc_out_q;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      acc_busy <= 1'b0;
    else
      acc_busy <= (state_q == PBT_MAIN) || (state_q == PBT_PERI && !req.done);
  end
endmodule

// ### logic/pbt_pkg.sv
/*
  constants for the peripheral access timing bridge: address map, bus
  selection, access sizes, clock-ratio defaults and cycle costs.
  assumes a single system clock; slower bus clocks are enable pulses.
*/
package pbt_pkg;
  // peripheral bus targets; bus 0 stands for the external bus control unit
  localparam logic [2:0] BUS_EXT  = 3'h0;
  localparam logic [2:0] BUS_P1   = 3'h1;
  localparam logic [2:0] BUS_P2   = 3'h2;
  localparam logic [2:0] BUS_P6   = 3'h6;
  // access sizes
  localparam logic [1:0] SZ_BYTE  = 2'h0;
  localparam logic [1:0] SZ_HALF  = 2'h1;
  localparam logic [1:0] SZ_WORD  = 2'h2;
  // interrupt unit register windows
  localparam logic [31:0] ADDR_INT_B_SEL_LO = 32'h000877BB;
  localparam logic [31:0] ADDR_INT_B_SEL_HI = 32'h000877CF;
  localparam logic [31:0] ADDR_GRP_REQ0     = 32'h00087830;
  localparam logic [31:0] ADDR_GRP_REQ1     = 32'h00087834;
  localparam logic [31:0] ADDR_GRP_EN0      = 32'h00087870;
  localparam logic [31:0] ADDR_GRP_EN1      = 32'h00087874;
  localparam logic [31:0] ADDR_INT_A_LO     = 32'h00087900;
  localparam logic [31:0] ADDR_INT_A_HI     = 32'h00087907;
  // bus-error registers of the external bus control unit, no sync added
  localparam logic [31:0] ADDR_BUS_ERR_LO   = 32'h00081300;
  localparam logic [31:0] ADDR_BUS_ERR_HI   = 32'h00081309;
  // main-bus cycles spent before the bridge, in core clocks
  localparam logic [3:0] MAIN_BUS_CYC      = 4'h2;
  // peripheral bus cycles once synchronised, in core clocks
  localparam logic [3:0] PERI_BUS_CYC      = 4'h0;
  // default divider ratios (core clocks per divided clock)
  localparam logic [3:0] DIV_A_DEF         = 4'h2;
  localparam logic [3:0] DIV_B_DEF         = 4'h4;
  localparam logic [3:0] DIV_EXT_DEF       = 4'h4;
endpackage

// ### logic/pbt_req_if.sv
/*
  request and answer carrier between the bridge front end and its sync
  stage. assumes both ends run on clk_sys.
*/
`timescale 1ns/1ps
interface pbt_req_if;
  logic       start;
  logic [2:0] bus;
  logic       need_sync;
  logic       done;
  modport front (output start, output bus, output need_sync, input done);
  modport sync  (input start, input bus, input need_sync, output done);
endinterface

// ### logic/pbt_sync.sv
/*
  divided clock synchronisation stage: waits for the next divided clock
  edge of the addressed bus, then counts the peripheral bus cycles.
  assumes enable pulses are one clk_sys wide and start is a pulse.
*/
`timescale 1ns/1ps
module pbt_sync (
  input  wire logic  clk_sys,
  input  wire logic  sys_rst,
  input  wire logic  en_a,
  input  wire logic  en_b,
  input  wire logic  en_ext,
  pbt_req_if.sync    req
);
  logic       busy_q;
  logic       wait_q;
  logic [2:0] bus_q;
  logic [3:0] cnt_q;
  logic       done_q;
  logic       edge_hit;

  // bus 1 runs on clock a, external unit on its own clock, others on b
  always_comb
  begin
    edge_hit = en_b;
    if (bus_q == pbt_pkg::BUS_P1)
      edge_hit = en_a;
    else if (bus_q == pbt_pkg::BUS_EXT)
      edge_hit = en_ext;
  end

  // wait length depends on where in the slow period the access began
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy_q <= 1'b0;
      wait_q <= 1'b0;
      bus_q  <= 3'h0;
      cnt_q  <= 4'h0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (!busy_q && req.start)
      begin
        busy_q <= 1'b1;
        wait_q <= req.need_sync;
        bus_q  <= req.bus;
        cnt_q  <= pbt_pkg::PERI_BUS_CYC;
      end
      else if (busy_q && wait_q)
      begin
        if (edge_hit)
          wait_q <= 1'b0;
      end
      else if (busy_q)
      begin
        if (cnt_q == 4'h0)
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        else
          cnt_q <= cnt_q - 4'h1;
      end
    end
  end

  assign req.done = done_q;
endmodule

// ### bench/pbt_bridge_props.sv
/*
  port-level timing checks for the access bridge.
  assumes one clk_sys domain, sys_rst async active high.
*/
`timescale 1ns/1ps
module pbt_bridge_props #(
  parameter logic [3:0] DIV_A   = pbt_pkg::DIV_A_DEF,
  parameter logic [3:0] DIV_B   = pbt_pkg::DIV_B_DEF,
  parameter logic [3:0] DIV_EXT = pbt_pkg::DIV_EXT_DEF
) (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        acc_req,
  input wire logic [31:0] acc_addr,
  input wire logic [1:0]  acc_size,
  input wire logic [2:0]  acc_bus,
  input wire logic        contend,
  input wire logic        acc_ready,
  input wire logic        acc_size_err,
  input wire logic [7:0]  acc_cycles,
  input wire logic        acc_busy
);
  // worst wait for a divided edge over all buses
  localparam int SAB  = (DIV_A > DIV_B) ? DIV_A : DIV_B;
  localparam int SMAX = (SAB > DIV_EXT) ? SAB : DIV_EXT;
  logic in_b, in_g, in_a, no_sync;
  // own decode, so a slip in the bridge decode is not mirrored here
  assign in_b = acc_addr inside {[pbt_pkg::ADDR_INT_B_SEL_LO:pbt_pkg::ADDR_INT_B_SEL_HI]};
  assign in_g = acc_addr inside {pbt_pkg::ADDR_GRP_REQ0, pbt_pkg::ADDR_GRP_REQ1,
                                 pbt_pkg::ADDR_GRP_EN0, pbt_pkg::ADDR_GRP_EN1};
  assign in_a = acc_addr inside {[pbt_pkg::ADDR_INT_A_LO:pbt_pkg::ADDR_INT_A_HI]};
  assign no_sync = in_g || in_a || (!in_b && (acc_bus == pbt_pkg::BUS_P1 ||
    (acc_bus == pbt_pkg::BUS_EXT &&
     acc_addr inside {[pbt_pkg::ADDR_BUS_ERR_LO:pbt_pkg::ADDR_BUS_ERR_HI]})));
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  AST_NOSYNC_COST:
    assert property ($rose(acc_busy) && $past(no_sync) |-> !acc_ready[*4] ##1
      (acc_ready && acc_cycles == 8'h05)) else $error("fixed cost wrong");
  AST_SYNC_WAIT:
    assert property ($rose(acc_busy) && !$past(no_sync) |-> !acc_ready[*5] ##[1:SMAX]
      acc_ready) else $error("sync cost out of range");
  AST_READY_PULSE:
    assert property (acc_ready |=> !acc_ready) else $error("ready too long");
  AST_NEXT_TAKE:
    assert property ((acc_ready && acc_req && !contend) ##1 (acc_req && !contend) |->
      ##2 acc_busy)
      else $error("held request not taken");
  AST_CONTEND_HOLD:
    assert property (!acc_busy && !acc_ready && contend && $past(contend) |=> !acc_busy)
      else $error("start under contention");
  AST_INTB_SIZE:
    assert property ($rose(acc_busy) && $past(in_b) |-> ##1
      acc_size_err == ($past(acc_size, 2) != pbt_pkg::SZ_BYTE)) else $error("int b size");
  AST_GRP_SIZE:
    assert property ($rose(acc_busy) && $past(in_g) |-> ##1
      acc_size_err == ($past(acc_size, 2) != pbt_pkg::SZ_WORD)) else $error("group size");
  AST_INTA_SIZE:
    assert property ($rose(acc_busy) && $past(in_a) |-> ##1
      acc_size_err == ($past(acc_size, 2) != pbt_pkg::SZ_BYTE)) else $error("int a size");
endmodule
bind pbt_bridge pbt_bridge_props #(.DIV_A(DIV_A), .DIV_B(DIV_B), .DIV_EXT(DIV_EXT))
  pbt_bridge_props_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .acc_req(acc_req),
  .acc_addr(acc_addr), .acc_size(acc_size), .acc_bus(acc_bus), .contend(contend),
  .acc_ready(acc_ready), .acc_size_err(acc_size_err), .acc_cycles(acc_cycles),
  .acc_busy(acc_busy));

// ### bench/pbt_master_model.sv
/*
  processor-side master: one register access at a time, plus contention.
  assumes clk_sys only.
*/
`timescale 1ns/1ps
module pbt_master_model (
  input  wire logic        clk_sys,
  input  wire logic        acc_ready,
  output logic             acc_req,
  output logic [31:0]      acc_addr,
  output logic [1:0]       acc_size,
  output logic [2:0]       acc_bus,
  output logic             contend
);
  // idle lines at time zero
  initial
  begin
    acc_req = 1'b0;
    acc_addr = 32'hFFFFFFFF;
    acc_size = 2'h0;
    acc_bus = 3'h1;
    contend = 1'b0;
  end
  // plain single accesses only; each waits for its own ready before the next
  task automatic access(input logic [31:0] a, input logic [1:0] s, input logic [2:0] b,
                        input bit keep);
    int n;
    if (!acc_req)
    begin
      @(posedge clk_sys);
      #1;
    end
    acc_req = 1'b1;
    acc_addr = a;
    acc_size = s;
    acc_bus = b;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    while (acc_ready !== 1'b1 && n < 64);
    // released address is inverted, never left on the old value
    if (!keep)
    begin
      acc_req = 1'b0;
      acc_addr = ~a;
    end
  endtask
  task automatic set_contend(input logic v);
    @(posedge clk_sys);
    #1 contend = v;
  endtask
endmodule

// ### bench/pbt_bridge_tb_top.sv
/*
  self-checking bench for the access bridge.
  assumes the master model drives every request.
*/
`timescale 1ns/1ps
module pbt_bridge_tb_top;
  localparam logic [3:0] TDA = 4'h2;
  localparam logic [3:0] TDB = 4'h3;
  localparam logic [3:0] TDE = 4'h4;
  typedef struct {int lo; int hi; logic err;} pbt_exp_t;
  logic clk_sys, sys_rst, acc_req, contend, acc_ready, acc_size_err, acc_busy;
  logic [31:0] acc_addr;
  logic [1:0]  acc_size;
  logic [2:0]  acc_bus;
  logic [7:0]  acc_cycles;
  int          fails, tests_run;
  pbt_exp_t    exp_q[$];
  logic [31:0] base_g[4] = '{pbt_pkg::ADDR_GRP_REQ0, pbt_pkg::ADDR_GRP_REQ1,
                             pbt_pkg::ADDR_GRP_EN0, pbt_pkg::ADDR_GRP_EN1};
  pbt_bridge #(.DIV_A(TDA), .DIV_B(TDB), .DIV_EXT(TDE)) pbt_bridge_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .acc_req(acc_req), .acc_addr(acc_addr),
    .acc_size(acc_size), .acc_bus(acc_bus), .contend(contend), .acc_ready(acc_ready),
    .acc_size_err(acc_size_err), .acc_cycles(acc_cycles), .acc_busy(acc_busy));
  pbt_master_model pbt_master_model_inst (.clk_sys(clk_sys), .acc_ready(acc_ready),
    .acc_req(acc_req), .acc_addr(acc_addr), .acc_size(acc_size), .acc_bus(acc_bus),
    .contend(contend));
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // expected cost window and size flag from the bus map
  function automatic pbt_exp_t exp_of(logic [31:0] a, logic [1:0] s, logic [2:0] b);
    pbt_exp_t e;
    int d;
    d = 0;
    e.err = 1'b0;
    if (a inside {[pbt_pkg::ADDR_INT_B_SEL_LO:pbt_pkg::ADDR_INT_B_SEL_HI]})
    begin
      d = TDB;
      e.err = (s !== pbt_pkg::SZ_BYTE);
    end
    else if (a inside {pbt_pkg::ADDR_GRP_REQ0, pbt_pkg::ADDR_GRP_REQ1, pbt_pkg::ADDR_GRP_EN0,
                       pbt_pkg::ADDR_GRP_EN1})
      e.err = (s !== pbt_pkg::SZ_WORD);
    else if (a inside {[pbt_pkg::ADDR_INT_A_LO:pbt_pkg::ADDR_INT_A_HI]})
      e.err = (s !== pbt_pkg::SZ_BYTE);
    else if (b == pbt_pkg::BUS_EXT)
      d = (a inside {[pbt_pkg::ADDR_BUS_ERR_LO:pbt_pkg::ADDR_BUS_ERR_HI]}) ? 0 : TDE;
    else if (b != pbt_pkg::BUS_P1)
      d = TDB;
    // five cycles without sync; with sync one to d more, waiting for the divided edge
    e.lo = (d == 0) ? 5 : 6;
    e.hi = 5 + d;
    return e;
  endfunction
  task automatic run(input logic [31:0] a, input logic [1:0] s, input logic [2:0] b,
                     input bit keep);
    exp_q.push_back(exp_of(a, s, b));
    pbt_master_model_inst.access(a, s, b, keep);
  endtask
  // plain space or one of the register windows, any size and bus
  task automatic rnd_one(input bit keep);
    logic [31:0] base[4];
    int span[4];
    int k;
    base = '{32'h00080000, pbt_pkg::ADDR_INT_B_SEL_LO, pbt_pkg::ADDR_INT_A_LO,
             pbt_pkg::ADDR_BUS_ERR_LO};
    span = '{65536, 21, 8, 10};
    k = $urandom % 4;
    run(base[k] + $urandom % span[k], 2'($urandom % 3), 3'($urandom % 7), keep);
  endtask
  task automatic finish_test;
    if (exp_q.size() != 0)
      fails++;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // oldest expectation against each completion
  always @(negedge clk_sys)
    if (acc_ready === 1'b1)
    begin
      pbt_exp_t e;
      e = (exp_q.size() != 0) ? exp_q.pop_front() : '{99, 0, 1'bx};
      tests_run++;
      if (((acc_cycles >= e.lo) && (acc_cycles <= e.hi)) !== 1'b1
          || acc_size_err !== e.err)
      begin
        fails++;
        $display("CHECK FAILED cost expected %0d..%0d/%b seen %0d/%b", e.lo, e.hi, e.err,
                 acc_cycles, acc_size_err);
      end
    end
  initial
  begin
    #2000000 fails++;
    finish_test();
  end
  initial
  begin
    fails = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    void'($urandom(58947));
    repeat (16) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    repeat (60) rnd_one(1'b0);
    foreach (base_g[i])
      for (int s = 0; s < 3; s++)
        run(base_g[i], 2'(s), 3'($urandom % 7), 1'b0);
    run(pbt_pkg::ADDR_INT_B_SEL_HI + 32'h1, pbt_pkg::SZ_HALF, pbt_pkg::BUS_P1, 1'b0);
    run(pbt_pkg::ADDR_INT_A_HI + 32'h1, pbt_pkg::SZ_WORD, pbt_pkg::BUS_P2, 1'b0);
    run(pbt_pkg::ADDR_BUS_ERR_HI + 32'h1, pbt_pkg::SZ_BYTE, pbt_pkg::BUS_EXT, 1'b0);
    $display("test windows done");
    repeat (6) rnd_one(1'b1);
    rnd_one(1'b0);
    $display("test back to back done");
    pbt_master_model_inst.set_contend(1'b1);
    fork
      run(32'h00088000, pbt_pkg::SZ_HALF, pbt_pkg::BUS_P1, 1'b0);
      begin
        repeat (12) @(posedge clk_sys);
        pbt_master_model_inst.set_contend(1'b0);
      end
    join
    $display("test contention done");
    // reset mid-access: outputs clear, the held request is served after
    fork
      run(32'h00088100, pbt_pkg::SZ_WORD, pbt_pkg::BUS_P6, 1'b0);
      begin
        repeat (2) @(posedge clk_sys);
        #1 sys_rst = 1'b1;
        @(posedge clk_sys);
        #2 tests_run++;
        if ({acc_busy, acc_ready, acc_cycles} !== 10'h000)
        begin
          fails++;
          $display("CHECK FAILED reset outputs expected 0 seen %b", {acc_busy, acc_ready});
        end
        @(posedge clk_sys);
        #1 sys_rst = 1'b0;
      end
    join
    // let the checker take the last completion off the queue before the verdict
    repeat (2) @(posedge clk_sys);
    $display("test reset done");
    finish_test();
  end
endmodule
